// ===== rtl/lpmc_pkg.sv
// Package of the low-power mode controller: register map, field layout,
// mode and request encodings, output and wake-source carriers.
// Assumes a 32-bit register port with word-aligned offsets.
package lpmc_pkg;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IOSTBY = 4'h8;

  // Status field positions
  localparam int ST_EFF_LSB    = 0;
  localparam int ST_APP_LSB    = 3;
  localparam int ST_MAIN_BIT   = 6;
  localparam int ST_LP_BIT     = 7;
  localparam int ST_RF_BIT     = 8;
  localparam int ST_PVDF_BIT   = 9;
  localparam int ST_PVDB_BIT   = 10;
  localparam int ST_PVM_BIT    = 11;
  localparam int ST_BYP_BIT    = 12;
  localparam int ST_BORL_LSB   = 13;

  // Deep-sleep target codes in the control register
  localparam logic [2:0] DEEP_STOP0    = 3'h0;
  localparam logic [2:0] DEEP_STOP1    = 3'h1;
  localparam logic [2:0] DEEP_STANDBY  = 3'h3;
  localparam logic [2:0] DEEP_SHUTDOWN = 3'h4;

  // Brownout levels; level 0 is the lowest (1.71 V) one
  localparam int         BOR_LEVELS    = 5;
  localparam logic [2:0] BOR_POR_LEVEL = 3'h0;

  // Multispeed oscillator range codes (encoding is local)
  localparam logic [3:0] MSI_4MHZ  = 4'h6;
  localparam logic [3:0] MSI_48MHZ = 4'hB;

  // Modes, ordered from lowest to highest power
  typedef enum logic [2:0] {
    M_SHUTDOWN, M_STANDBY, M_STOP1, M_STOP0,
    M_LPSLEEP, M_LPRUN, M_SLEEP, M_RUN
  } lpmc_mode_type;

  // Power state asked for by the radio subsystem
  typedef enum logic [1:0] {
    RF_OFF, RF_STANDBY, RF_STOP, RF_RUN
  } lpmc_radio_type;

  // Control register layout
  typedef struct packed {
    logic [14:0] rsvd;
    logic        wakePinFall;
    logic [3:0]  msiRange;
    logic        stopWakeHsi;
    logic [1:0]  vosRange;
    logic        bypassAutoEn;
    logic        pvdFall;
    logic        pvdRise;
    logic        pvdEn;
    logic        sramRetain;
    logic        lpRunReq;
    logic [2:0]  deepSel;
  } lpmc_ctrl_type;

  localparam lpmc_ctrl_type CTRL_RESET = '{
    rsvd: 15'h0000, wakePinFall: 1'b0, msiRange: MSI_4MHZ,
    stopWakeHsi: 1'b0, vosRange: 2'h0, bypassAutoEn: 1'b0,
    pvdFall: 1'b0, pvdRise: 1'b0, pvdEn: 1'b0, sramRetain: 1'b0,
    lpRunReq: 1'b0, deepSel: DEEP_STOP0};

  // Power and clock controls driven out
  typedef struct packed {
    logic       mainRegOn;
    logic       lpRegOn;
    logic       radioRegOn;
    logic       coreDomainOn;
    logic       coreClkOn;
    logic       periphClkOn;
    logic       coreClkLimit;
    logic       hsiOn;
    logic       lsOscOn;
    logic       sramRetain;
    logic       borMonOn;
    logic       bypassForce;
    logic       chipReset;
    logic       sysClkHsi;
    logic [3:0] msiRange;
    logic [1:0] vosRange;
    logic       pvdIrq;
    logic       pvmOk;
  } lpmc_out_type;

  // Standby wake sources, level high when active; Shutdown wakes only on extReset, wakeupPin and rtcEvent
  typedef struct packed {
    logic extReset;
    logic watchdogReset;
    logic wakeupPin;
    logic rtcEvent;
    logic lseFail;
    logic radioWake;
  } lpmc_wake_type;

endpackage

// ===== rtl/low_power_mode_controller.sv
// Low-power mode controller: mode state machine, regulator and clock
// selection, brownout hold, threshold detector and register port.
// Assumes analog comparators and option settings arrive synchronous.
//
// Overview of operation
// - Main regulator in Run, Sleep, Stop 0
// - Low-power regulator in LP modes, Stop 1
// - Standby and Shutdown switch all regulators off, except the low-power one for Standby SRAM retention
// - Radio regulator follows radio request, forced off in LP modes, Standby, Shutdown
// - LP run limits core clock, radio off
// - LP sleep only from LP run
// - LP sleep wakes back to LP run
// - Hold reset below brownout, except Shutdown
// - Lowest brownout level until options load
// - Threshold detector interrupts on chosen edges
// - Report analog supply inside functional range
// - Auto bypass of converter below level
// - Core voltage scaling in Run
// - Start in Run, leave by software
// - Sleep stops core only, any event wakes
// - Stop keeps SRAM and slow oscillator
// - Stop lets peripherals request 16 MHz oscillator
// - Stop 0 keeps main regulator on
// - Stop exit clock chosen by software
// - Standby drops core, optional SRAM retention
// - Standby drives selected I/O pulls
// - Standby exits on listed wake sources
// - Standby wake runs 16 MHz oscillator
// - Shutdown wake runs multispeed at 4 MHz
// - Higher of core and radio requests wins
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module low_power_mode_controller
  import lpmc_pkg::*;
#(
  parameter int NIO = 8
)(
  // Clock and power-on reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Register port
  input  wire logic [3:0]     addr,
  input  wire logic [31:0]    wdata,
  input  wire logic           wr,
  input  wire logic           rd,
  output logic      [31:0]    rdata,
  // Application core
  input  wire logic           wfiReq,
  input  wire logic           deepSleep,
  input  wire logic           wakeEvent,
  // Radio subsystem
  input  wire lpmc_radio_type radioReq,
  input  wire logic           radioRegReq,
  // Wake sources and peripheral clock demand
  input  wire lpmc_wake_type  wake,
  input  wire logic           periphHsiReq,
  // Analog monitors, bit i high when supply is below brownout level i
  input  wire logic [BOR_LEVELS-1:0] borCmp,
  input  wire logic           pvdBelow,
  input  wire logic           analogOk,
  // Option settings
  input  wire logic           optValid,
  input  wire logic [2:0]     optBorLevel,
  input  wire logic [2:0]     optBypassLevel,
  // Power controls and standby I/O pulls
  output lpmc_out_type        pwr,
  output logic [NIO-1:0]      ioPullUp,
  output logic [NIO-1:0]      ioPullDown
);

  // Whole state of the block
  typedef struct packed {
    lpmc_mode_type  appMode;    // Mode asked by the core
    lpmc_mode_type  effMode;    // Mode actually in force
    lpmc_ctrl_type  ctrl;       // Control register
    logic [2*NIO-1:0] ioCfg;    // Standby pull selection
    logic           pvdFlag;    // Sticky detector event
    logic           pvdPrev;    // Detector level last cycle
    logic           pinPrev;    // Wake pin level last cycle
    logic [2:0]     borLevel;   // Brownout level in use
    lpmc_out_type   out;
    logic [NIO-1:0] ioUp;
    logic [NIO-1:0] ioDn;
    logic [31:0]    rdata;
  } lpmc_state_type;

  lpmc_state_type s;
  lpmc_state_type next_s;

  logic borBelow;     // Supply under active brownout level
  logic bypassBelow;  // Supply under the bypass level
  lpmc_mode_type rfMode;

  // Comparator pick; out-of-range levels count as the top level
  function automatic logic cmpAt(logic [2:0] lvl, logic [BOR_LEVELS-1:0] c);
    logic r;
    r = c[BOR_LEVELS-1];
    for (int i = 0; i < BOR_LEVELS; i++)
    begin
      if (lvl == 3'(i))
      begin
        r = c[i];
      end
    end
    return r;
  endfunction

  // Stop 0 or Stop 1
  function automatic logic isStop(lpmc_mode_type m);
    return (m == M_STOP0) || (m == M_STOP1);
  endfunction

  assign borBelow    = cmpAt(s.borLevel, borCmp);
  assign bypassBelow = cmpAt(optBypassLevel, borCmp);

  // Radio request seen as a mode floor
  always_comb
  begin
    unique case (radioReq)
      RF_RUN:     rfMode = M_SLEEP;
      RF_STOP:    rfMode = M_STOP1;
      RF_STANDBY: rfMode = M_STANDBY;
      RF_OFF:     rfMode = M_SHUTDOWN;
    endcase
  end

  // Next-state logic
  always_comb
  begin
    logic pinEdge;
    logic stbyWake;
    logic shutWake;
    lpmc_mode_type deepMode;
    next_s = s;
    pinEdge = 1'b0;
    stbyWake = 1'b0;
    shutWake = 1'b0;
    deepMode = M_STOP0;
    next_s.rdata = 32'h0000_0000;
    next_s.out.chipReset = 1'b0;
    next_s.pvdPrev = pvdBelow;
    next_s.pinPrev = wake.wakeupPin;

    // Higher brownout level once options are loaded
    if (optValid)
    begin
      next_s.borLevel = optBorLevel;
    end

    // Read answer the cycle after the strobe
    if (rd)
    begin
      unique case (addr)
        REG_CTRL:   next_s.rdata = s.ctrl;
        REG_STATUS:
        begin
          next_s.rdata[ST_EFF_LSB +: 3]  = s.effMode;
          next_s.rdata[ST_APP_LSB +: 3]  = s.appMode;
          next_s.rdata[ST_MAIN_BIT]      = s.out.mainRegOn;
          next_s.rdata[ST_LP_BIT]        = s.out.lpRegOn;
          next_s.rdata[ST_RF_BIT]        = s.out.radioRegOn;
          next_s.rdata[ST_PVDF_BIT]      = s.pvdFlag;
          next_s.rdata[ST_PVDB_BIT]      = pvdBelow;
          next_s.rdata[ST_PVM_BIT]       = analogOk;
          next_s.rdata[ST_BYP_BIT]       = s.out.bypassForce;
          next_s.rdata[ST_BORL_LSB +: 3] = s.borLevel;
        end
        REG_IOSTBY: next_s.rdata = 32'(s.ioCfg);
        default:    next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes; reserved control bits stay zero
    if (wr && addr == REG_CTRL)
    begin
      next_s.ctrl = wdata;
      next_s.ctrl.rsvd = 15'h0000;
    end
    if (wr && addr == REG_IOSTBY)
    begin
      next_s.ioCfg = wdata[2*NIO-1:0];
    end
    if (wr && addr == REG_STATUS && wdata[ST_PVDF_BIT])
    begin
      next_s.pvdFlag = 1'b0;
    end

    // Detector edges; a new event beats a clear in the same cycle
    if (s.ctrl.pvdEn &&
        ((s.ctrl.pvdFall && pvdBelow && !s.pvdPrev) ||
         (s.ctrl.pvdRise && !pvdBelow && s.pvdPrev)))
    begin
      next_s.pvdFlag = 1'b1;
    end

    // Wake pin edge of the chosen polarity
    pinEdge = s.ctrl.wakePinFall ? (s.pinPrev && !wake.wakeupPin)
                                 : (!s.pinPrev && wake.wakeupPin);
    stbyWake = wake.extReset || wake.watchdogReset || pinEdge ||
               wake.rtcEvent || wake.lseFail || wake.radioWake;
    shutWake = wake.extReset || pinEdge || wake.rtcEvent;

    // Deep-sleep target; undefined codes fall back to Stop 1
    unique case (s.ctrl.deepSel)
      DEEP_STOP0:    deepMode = M_STOP0;
      DEEP_STANDBY:  deepMode = M_STANDBY;
      DEEP_SHUTDOWN: deepMode = M_SHUTDOWN;
      default:       deepMode = M_STOP1;
    endcase

    // Core mode machine; low-power entry only by software
    unique case (s.appMode)
      M_RUN:
      begin
        if (wfiReq)
        begin
          next_s.appMode = deepSleep ? deepMode : M_SLEEP;
        end
        else if (s.ctrl.lpRunReq)
        begin
          next_s.appMode = M_LPRUN;
        end
      end
      M_LPRUN:
      begin
        if (wfiReq)
        begin
          next_s.appMode = deepSleep ? deepMode : M_LPSLEEP;
        end
        else if (!s.ctrl.lpRunReq)
        begin
          next_s.appMode = M_RUN;
        end
      end
      M_SLEEP:
      begin
        if (wakeEvent)
        begin
          next_s.appMode = M_RUN;
        end
      end
      M_LPSLEEP:
      begin
        if (wakeEvent)
        begin
          next_s.appMode = M_LPRUN;
        end
      end
      M_STOP0, M_STOP1:
      begin
        // Software must pick the 16 MHz source while the radio runs
        if (wakeEvent)
        begin
          next_s.appMode = M_RUN;
          next_s.ctrl.lpRunReq = 1'b0;
          next_s.out.sysClkHsi = s.ctrl.stopWakeHsi;
          next_s.out.msiRange = s.ctrl.msiRange;
        end
      end
      M_STANDBY:
      begin
        // Core registers are lost; I/O pull settings survive
        if (stbyWake)
        begin
          next_s.appMode = M_RUN;
          next_s.ctrl = CTRL_RESET;
          next_s.pvdFlag = 1'b0;
          next_s.out.chipReset = 1'b1;
          next_s.out.sysClkHsi = 1'b1;
        end
      end
      M_SHUTDOWN:
      begin
        if (shutWake)
        begin
          next_s.appMode = M_RUN;
          next_s.ctrl = CTRL_RESET;
          next_s.pvdFlag = 1'b0;
          next_s.borLevel = BOR_POR_LEVEL;
          next_s.out.chipReset = 1'b1;
          next_s.out.sysClkHsi = 1'b0;
          next_s.out.msiRange = MSI_4MHZ;
        end
      end
    endcase

    // Brownout holds the chip; the monitor is off in Shutdown
    if (borBelow && s.effMode != M_SHUTDOWN)
    begin
      next_s.appMode = M_RUN;
      next_s.ctrl = CTRL_RESET;
      next_s.pvdFlag = 1'b0;
      next_s.out.chipReset = 1'b1;
      next_s.out.sysClkHsi = 1'b0;
      next_s.out.msiRange = MSI_4MHZ;
    end

    // Effective mode is the higher of the two requests
    next_s.effMode = (rfMode > next_s.appMode) ? rfMode
                                               : next_s.appMode;

    // Regulators, clocks and retention per effective mode
    unique case (next_s.effMode)
      M_RUN, M_SLEEP, M_STOP0: next_s.out.mainRegOn = 1'b1;
      default:                 next_s.out.mainRegOn = 1'b0;
    endcase
    next_s.out.lpRegOn =
      (next_s.effMode inside {M_LPRUN, M_LPSLEEP, M_STOP1}) ||
      (next_s.effMode == M_STANDBY && s.ctrl.sramRetain);
    // Standby powers down the main and radio regulators; the low-power one stays on only for SRAM retention
    next_s.out.radioRegOn = radioRegReq && !(next_s.effMode inside
      {M_LPRUN, M_LPSLEEP, M_STANDBY, M_SHUTDOWN});
    next_s.out.coreDomainOn =
      !(next_s.effMode inside {M_STANDBY, M_SHUTDOWN});
    next_s.out.coreClkOn = next_s.effMode inside {M_RUN, M_LPRUN};
    next_s.out.periphClkOn =
      next_s.effMode inside {M_RUN, M_SLEEP, M_LPRUN, M_LPSLEEP};
    next_s.out.coreClkLimit = next_s.effMode == M_LPRUN;
    // Peripherals may pull in the 16 MHz source in any mode but Standby and Shutdown
    next_s.out.hsiOn = (next_s.effMode inside {M_RUN, M_SLEEP})
      ? next_s.out.sysClkHsi || periphHsiReq
      : periphHsiReq && next_s.out.coreDomainOn;
    next_s.out.lsOscOn = next_s.effMode != M_SHUTDOWN;
    next_s.out.sramRetain = isStop(next_s.effMode) ||
      (next_s.effMode == M_STANDBY && s.ctrl.sramRetain);
    next_s.out.borMonOn = next_s.effMode != M_SHUTDOWN;
    // Forced bypass is not available in Stop 1 and below
    next_s.out.bypassForce = s.ctrl.bypassAutoEn && bypassBelow &&
      (next_s.effMode > M_STOP1);
    next_s.out.vosRange = next_s.out.mainRegOn ? s.ctrl.vosRange
                                               : s.out.vosRange;
    next_s.out.pvdIrq = next_s.pvdFlag;
    next_s.out.pvmOk = analogOk;

    // Standby pulls; pull-up wins if both are chosen
    for (int i = 0; i < NIO; i++)
    begin
      next_s.ioUp[i] = next_s.effMode == M_STANDBY && s.ioCfg[i];
      next_s.ioDn[i] = next_s.effMode == M_STANDBY && !s.ioCfg[i] &&
                       s.ioCfg[NIO+i];
    end
  end

  // State register; reset enters Run with brownout at its lowest level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{appMode: M_RUN, effMode: M_RUN, ctrl: CTRL_RESET,
             borLevel: BOR_POR_LEVEL,
             out: '{mainRegOn: 1'b1, coreDomainOn: 1'b1,
                    coreClkOn: 1'b1, periphClkOn: 1'b1,
                    lsOscOn: 1'b1, borMonOn: 1'b1, chipReset: 1'b1,
                    msiRange: MSI_4MHZ, default: '0},
             default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rdata      = s.rdata;
  assign pwr        = s.out;
  assign ioPullUp   = s.ioUp;
  assign ioPullDown = s.ioDn;

  // Checks on the driven outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence lpSleepWake;
    s.appMode == M_LPSLEEP && wakeEvent && !borBelow;
  endsequence

  sequence pvdFallEdge;
    s.ctrl.pvdEn && s.ctrl.pvdFall && !pvdBelow ##1 pvdBelow;
  endsequence

  a_main_reg: assert property (pwr.mainRegOn ==
    (s.effMode inside {M_RUN, M_SLEEP, M_STOP0}))
    else $error("main regulator does not match mode");
  a_lp_reg: assert property (s.effMode inside {M_LPRUN, M_STOP1}
    |-> pwr.lpRegOn && !pwr.mainRegOn)
    else $error("low-power regulator off in low-power mode");
  a_standby_off: assert property (s.effMode inside {M_STANDBY,
    M_SHUTDOWN} |-> !pwr.mainRegOn && !pwr.radioRegOn &&
    pwr.lpRegOn == pwr.sramRetain)
    else $error("regulator on in standby or shutdown");
  a_radio_reg: assert property (pwr.radioRegOn
    |-> $past(radioRegReq))
    else $error("radio regulator on without request");
  a_lprun_limit: assert property (s.effMode == M_LPRUN
    |-> pwr.coreClkLimit && !pwr.radioRegOn)
    else $error("low-power run without clock limit");
  a_lpsleep_wake: assert property (lpSleepWake
    |=> s.appMode == M_LPRUN)
    else $error("low-power sleep did not return to low-power run");
  a_bor_hold: assert property (borBelow && s.effMode != M_SHUTDOWN
    |=> pwr.chipReset && s.appMode == M_RUN)
    else $error("brownout did not hold reset");
  a_bor_por: assert property ($rose(rst_n) |-> s.borLevel ==
    BOR_POR_LEVEL)
    else $error("brownout level not lowest after reset");
  a_pvd_event: assert property (pvdFallEdge
    |=> pwr.pvdIrq && s.pvdFlag)
    else $error("falling detector edge not flagged");
  a_bypass: assert property (pwr.bypassForce
    |-> $past(s.ctrl.bypassAutoEn && bypassBelow) && s.effMode > M_STOP1)
    else $error("bypass forced without cause");
  a_stop_keep: assert property (isStop(s.effMode)
    |-> pwr.sramRetain && pwr.lsOscOn && pwr.coreDomainOn)
    else $error("stop mode lost retention");
  a_stby_clock: assert property (s.appMode == M_STANDBY &&
    wake.rtcEvent && !borBelow |=> pwr.sysClkHsi && pwr.chipReset)
    else $error("standby wake clock not 16 MHz");
  a_shut_clock: assert property (s.appMode == M_SHUTDOWN &&
    wake.extReset |=> !pwr.sysClkHsi && pwr.msiRange == MSI_4MHZ)
    else $error("shutdown wake clock not 4 MHz");
  a_higher_mode: assert property (s.effMode >= s.appMode &&
    s.effMode >= $past(rfMode))
    else $error("effective mode below a request");

endmodule

// ===== bench/lpmc_core_model.sv
// Partner model: application core software and radio subsystem requests.
// Assumes the bench calls its tasks from one process, after reset release.
`timescale 1ns/1ps
module lpmc_core_model
  import lpmc_pkg::*;
(
  // Clock
  input  wire logic      clk,
  // Core requests
  output logic           wfiReq,
  output logic           deepSleep,
  output logic           wakeEvent,
  // Radio requests
  output lpmc_radio_type radioReq,
  output logic           radioRegReq
);
  // Idle at time zero: no request, radio fully off
  initial
  begin
    wfiReq      = 1'b0;
    deepSleep   = 1'b0;
    wakeEvent   = 1'b0;
    radioReq    = RF_OFF;
    radioRegReq = 1'b0;
  end

  // Wait instruction; the caller has already written the mode field
  task automatic sleep(input logic deep);
    @(posedge clk);
    wfiReq    <= 1'b1;
    deepSleep <= deep;
    @(posedge clk);
    wfiReq    <= 1'b0;
  endtask

  // One-cycle interrupt or event toward the core
  task automatic wake_up;
    @(posedge clk);
    wakeEvent <= 1'b1;
    @(posedge clk);
    wakeEvent <= 1'b0;
  endtask

  // Radio sets its floor; it wants its regulator only while running
  task automatic radio(input lpmc_radio_type req);
    @(posedge clk);
    radioReq    <= req;
    radioRegReq <= (req == RF_RUN);
  endtask
endmodule

// ===== bench/low_power_mode_controller_tb.sv
// Self-checking bench for the low-power mode controller.
// Assumes the register port answers one cycle after the read strobe.
`timescale 1ns/1ps
module low_power_mode_controller_tb
  import lpmc_pkg::*;
;
  // Clock, reset and register port
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  // Requests from the partner model
  logic wfiReq, deepSleep, wakeEvent, radioRegReq;
  lpmc_radio_type radioReq;
  // Wake sources, monitors and options
  lpmc_wake_type wake = '0;
  logic periphHsiReq = 1'b0;
  logic [BOR_LEVELS-1:0] borCmp = '0;
  logic pvdBelow = 1'b0;
  logic analogOk = 1'b1;
  logic optValid = 1'b1;
  logic [2:0] optBorLevel = 3'h0;
  logic [2:0] optBypassLevel = 3'h2;
  // Outputs
  lpmc_out_type pwr;
  logic [7:0] ioPullUp, ioPullDown;
  // Bookkeeping
  int errors = 0;
  int checkCount = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  low_power_mode_controller low_power_mode_controller_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .wfiReq(wfiReq), .deepSleep(deepSleep),
    .wakeEvent(wakeEvent), .radioReq(radioReq),
    .radioRegReq(radioRegReq), .wake(wake), .periphHsiReq(periphHsiReq),
    .borCmp(borCmp), .pvdBelow(pvdBelow), .analogOk(analogOk),
    .optValid(optValid), .optBorLevel(optBorLevel),
    .optBypassLevel(optBypassLevel), .pwr(pwr), .ioPullUp(ioPullUp),
    .ioPullDown(ioPullDown));

  lpmc_core_model lpmc_core_model_i (
    .clk(clk), .wfiReq(wfiReq), .deepSleep(deepSleep),
    .wakeEvent(wakeEvent), .radioReq(radioReq),
    .radioRegReq(radioRegReq));

  // Verdict and end of run, reached from the sequence or the watchdog
  task automatic testDone;
    $display("checks=%0d errors=%0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Four-state compare so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data is taken only in the cycle after the strobe
  task automatic regRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Let registered outputs land
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Pick a deep mode, then execute the wait instruction
  task automatic deepEnter(input logic [31:0] ctrl);
    regWrite(REG_CTRL, ctrl);
    lpmc_core_model_i.sleep(1'b1);
    settle;
  endtask

  // Pulse one standby wake source
  task automatic pulseWake(input logic [5:0] src);
    @(posedge clk);
    wake <= lpmc_wake_type'(src);
    @(posedge clk);
    wake <= '0;
    settle;
  endtask

  // Hang guard, far above the length of the sequence
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      errors++;
      testDone;
    end
  end

  initial
  begin
    logic [31:0] st;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    // Reset state and an unmapped address
    regRead(REG_STATUS, st);
    chk(st[5:0], {M_RUN, M_RUN});
    chk(st[15:13], BOR_POR_LEVEL);
    chk({pwr.mainRegOn, pwr.borMonOn}, 2'b11);
    regRead(4'hC, st);
    chk(st, 32'h0);
    // Sleep stops the core only; an event wakes it
    lpmc_core_model_i.sleep(1'b0);
    settle;
    chk({pwr.mainRegOn, pwr.coreClkOn, pwr.periphClkOn}, 3'b101);
    lpmc_core_model_i.wake_up;
    settle;
    regRead(REG_STATUS, st);
    chk(st[5:3], M_RUN);
    // Stop 1 with a peripheral asking for the 16 MHz oscillator
    periphHsiReq <= 1'b1;
    deepEnter(32'h0000_B801);
    chk({pwr.mainRegOn, pwr.lpRegOn, pwr.sramRetain, pwr.lsOscOn,
         pwr.hsiOn}, 5'b01111);
    lpmc_core_model_i.wake_up;
    settle;
    chk({pwr.mainRegOn, pwr.sysClkHsi, pwr.msiRange},
        {2'b11, MSI_48MHZ});
    periphHsiReq <= 1'b0;
    // Stop 0 keeps the main regulator
    deepEnter(32'h0000_0000);
    chk({pwr.mainRegOn, pwr.lpRegOn, pwr.coreClkOn}, 3'b100);
    lpmc_core_model_i.wake_up;
    settle;
    // Radio running lifts a Stop 1 core to Sleep; HSI exit since radio used
    regWrite(REG_CTRL, 32'h0000_0801);
    lpmc_core_model_i.radio(RF_RUN);
    lpmc_core_model_i.sleep(1'b1);
    settle;
    regRead(REG_STATUS, st);
    chk(st[5:0], {M_STOP1, M_SLEEP});
    chk({pwr.radioRegOn, pwr.mainRegOn}, 2'b11);
    lpmc_core_model_i.radio(RF_OFF);
    settle;
    chk({pwr.radioRegOn, pwr.mainRegOn, pwr.lpRegOn}, 3'b001);
    lpmc_core_model_i.wake_up;
    settle;
    // Low-power run with radio off, its sleep and its wake
    regWrite(REG_CTRL, 32'h0000_0008);
    settle;
    chk({pwr.mainRegOn, pwr.lpRegOn, pwr.coreClkLimit}, 3'b011);
    lpmc_core_model_i.sleep(1'b0);
    settle;
    regRead(REG_STATUS, st);
    chk({st[5:3], pwr.coreClkOn}, {M_LPSLEEP, 1'b0});
    lpmc_core_model_i.wake_up;
    settle;
    regRead(REG_STATUS, st);
    chk(st[5:3], M_LPRUN);
    // Back to Run with a new core voltage range
    regWrite(REG_CTRL, 32'h0000_0400);
    settle;
    chk(pwr.vosRange, 2'h2);
    // Standby, once with retention, left by every wake source
    for (int i = 0; i < 6; i++)
    begin
      regWrite(REG_IOSTBY, 32'h0000_5AA5);
      deepEnter(i == 0 ? 32'h0000_0013 : 32'h0000_0003);
      chk({pwr.mainRegOn, pwr.lpRegOn, pwr.coreDomainOn, pwr.borMonOn},
          i == 0 ? 4'b0101 : 4'b0001);
      chk({ioPullDown, ioPullUp}, 16'h5AA5);
      pulseWake(6'h20 >> i);
      chk({pwr.coreDomainOn, pwr.sysClkHsi}, 2'b11);
      regRead(REG_STATUS, st);
      chk(st[5:3], M_RUN);
    end
    regRead(REG_IOSTBY, st);
    chk(st, 32'h0000_5AA5);
    // Falling wake-pin polarity; the pin is already high on entry
    wake <= 6'h08;
    deepEnter(32'h0001_0003);
    chk(pwr.coreDomainOn, 1'b0);
    pulseWake(6'h00);
    chk({pwr.coreDomainOn, pwr.sysClkHsi}, 2'b11);
    // Radio stop floor lifts a Standby core to Stop 1
    lpmc_core_model_i.radio(RF_STOP);
    deepEnter(32'h0000_0003);
    regRead(REG_STATUS, st);
    chk(st[5:0], {M_STANDBY, M_STOP1});
    chk({pwr.mainRegOn, pwr.lpRegOn, pwr.coreDomainOn}, 3'b011);
    pulseWake(6'h20);
    lpmc_core_model_i.radio(RF_OFF);
    // Shutdown ignores brownout, then wakes on the multispeed clock
    deepEnter(32'h0000_0004);
    borCmp <= 5'h01;
    settle;
    chk({pwr.coreDomainOn, pwr.borMonOn, pwr.lpRegOn}, 3'b000);
    borCmp <= 5'h00;
    pulseWake(6'h20);
    chk({pwr.sysClkHsi, pwr.msiRange}, {1'b0, MSI_4MHZ});
    // Brownout in Stop 0 holds reset and returns to Run
    deepEnter(32'h0000_0000);
    borCmp <= 5'h01;
    settle;
    chk(pwr.chipReset, 1'b1);
    borCmp <= 5'h00;
    settle;
    regRead(REG_STATUS, st);
    chk({pwr.chipReset, st[5:3]}, {1'b0, M_RUN});
    // Detector on falling supply only, flag cleared by writing one
    regWrite(REG_CTRL, 32'h0000_00A0);
    // Let the enable land first so the edge is seen against it
    @(posedge clk);
    pvdBelow <= 1'b1;
    settle;
    chk(pwr.pvdIrq, 1'b1);
    regWrite(REG_STATUS, 32'h0000_0200);
    pvdBelow <= 1'b0;
    settle;
    chk(pwr.pvdIrq, 1'b0);
    // Analog supply monitor
    analogOk <= 1'b0;
    settle;
    chk(pwr.pvmOk, 1'b0);
    analogOk <= 1'b1;
    // Converter bypass below the option level when enabled
    regWrite(REG_CTRL, 32'h0000_0100);
    regRead(REG_CTRL, st);
    chk(st, 32'h0000_0100);
    borCmp <= 5'h04;
    settle;
    chk(pwr.bypassForce, 1'b1);
    borCmp <= 5'h00;
    settle;
    chk(pwr.bypassForce, 1'b0);
    testDone;
  end
endmodule
